/* hdl/acl_pkg.sv */
// Shared types and constants for the IP access-list packet classifier.
// Assumes one switch clock, an APB register port and a same-clock header feed.

package acl_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses on APB)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SRC_ADDR = 8'h04;
    localparam logic [7:0] OFF_SRC_MASK = 8'h08;
    localparam logic [7:0] OFF_DST_ADDR = 8'h0c;
    localparam logic [7:0] OFF_DST_MASK = 8'h10;
    localparam logic [7:0] OFF_L4_PORTS = 8'h14;
    localparam logic [7:0] OFF_SERVICE = 8'h18;
    localparam logic [7:0] OFF_CMD = 8'h1c;
    localparam logic [7:0] OFF_BIND = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    localparam logic [7:0] OFF_VERDICT = 8'h28;

    localparam int unsigned PORT_W = 4;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
    localparam logic [31:0] MASK_ALL = 32'hffff_ffff;
    localparam logic [7:0] DSCP_MASK = 8'hfc;
    localparam logic [7:0] PREC_MASK = 8'he0;
    localparam int unsigned DSCP_SHIFT = 2;
    localparam int unsigned PREC_SHIFT = 5;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {CRIT_OFF, CRIT_NUMBER, CRIT_SYMBOL, CRIT_RSVD} crit_mode_t;
    typedef enum logic [1:0] {SVC_NONE, SVC_DSCP, SVC_PREC, SVC_MASKED} svc_mode_t;
    typedef enum logic [1:0] {CMD_NONE, CMD_ADD, CMD_UPDATE, CMD_DELETE} cmd_op_t;

    // ------------------------------------------------------------------
    // Register layouts
    // ------------------------------------------------------------------
    typedef struct packed {
        crit_mode_t dport_mode;
        crit_mode_t sport_mode;
        svc_mode_t svc_mode;
        crit_mode_t proto_mode;
        logic [7:0] proto;
        logic [4:0] rsvd;
        logic [PORT_W-1:0] redir_port;
        logic redir_en;
        logic [2:0] egress_queue_select;
        logic queue_en;
        logic match_all;
        logic permit;
    } rule_ctrl_t;

    typedef struct packed {
        logic [23:0] rsvd;
        logic [3:0] rule_id;
        logic [1:0] rsvd2;
        cmd_op_t op;
    } cmd_t;

    // Resolved form of one rule, as the match logic uses it.
    typedef struct packed {
        logic valid;
        logic permit;
        logic match_all;
        logic queue_en;
        logic [2:0] queue;
        logic redir_en;
        logic [PORT_W-1:0] redir_port;
        logic proto_en;
        logic [7:0] proto;
        logic [31:0] src_addr;
        logic [31:0] src_mask;
        logic [31:0] dst_addr;
        logic [31:0] dst_mask;
        logic sport_en;
        logic [15:0] sport_lo;
        logic [15:0] sport_hi;
        logic dport_en;
        logic [15:0] dport_lo;
        logic [15:0] dport_hi;
        logic [7:0] svc_val;
        logic [7:0] svc_mask;
    } rule_t;

    typedef struct packed {
        logic [31:0] src_addr;
        logic [31:0] dst_addr;
        logic [7:0] proto;
        logic [7:0] svc;
        logic [15:0] sport;
        logic [15:0] dport;
        logic [PORT_W-1:0] in_port;
        logic outbound;
    } pkt_hdr_t;

    typedef struct packed {
        logic applied;
        logic hit;
        logic permit;
        logic [3:0] rule_id;
        logic queue_en;
        logic [2:0] queue;
        logic redir_en;
        logic [PORT_W-1:0] redir_port;
    } verdict_t;

    // Symbolic layer-4 port choices to well-known numbers.
    function automatic logic [15:0] l4_port_of(input logic [3:0] code);
        case (code)
            4'h0: l4_port_of = 16'h0035;
            4'h1: l4_port_of = 16'h0007;
            4'h2: l4_port_of = 16'h0015;
            4'h3: l4_port_of = 16'h0014;
            4'h4: l4_port_of = 16'h0050;
            4'h5: l4_port_of = 16'h0019;
            4'h6: l4_port_of = 16'h00a1;
            4'h7: l4_port_of = 16'h0017;
            4'h8: l4_port_of = 16'h0045;
            default: l4_port_of = 16'h0050;
        endcase
    endfunction : l4_port_of

    // Protocol keywords: 0 ICMP, 1 IGMP, 2 IP (any), 3 TCP, 4 UDP.
    localparam logic [7:0] PROTO_KW_IP = 8'h02;
    function automatic logic [7:0] proto_of(input logic [7:0] code);
        case (code)
            8'h00: proto_of = 8'h01;
            8'h01: proto_of = 8'h02;
            8'h03: proto_of = 8'h06;
            default: proto_of = 8'h11;
        endcase
    endfunction : proto_of

endpackage : acl_pkg

/* hdl/ip_acl_packet_classifier.sv */
// IP access-list classifier: rule table loaded over APB, one verdict per header.
// Assumes headers arrive from same-clock pipeline logic, one per cycle at most.
//
// Local design decisions: the address map and the APB slave port.

// What this block does
// - hit needs every configured criterion matching
// - at most nine rules, ids one to nine
// - add refused when list already full
// - each rule permits or denies on hit
// - permit rule may force egress queue
// - permit rule may redirect to port
// - match-all rule hits every packet
// - protocol number one to 255 compared
// - protocol keyword alternative, one value held
// - masked source address compare
// - masked destination address compare
// - source keyword becomes single-value range
// - numeric source port compared exactly
// - destination keyword becomes single-value range
// - numeric destination port must equal value
// - one service criterion of three kinds
// - DSCP compares upper six bits
// - precedence compares upper three bits
// - masked service byte compare
// - first hit in order decides
// - list applies to bound ports, direction
module ip_acl_packet_classifier #(
    parameter int unsigned MAX_RULES = 9,
    parameter int unsigned NUM_PORTS = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pkt_valid,
    input wire acl_pkg::pkt_hdr_t pkt,
    output logic verdict_valid,
    output acl_pkg::verdict_t verdict
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    acl_pkg::rule_ctrl_t ctrl_reg;
    logic [31:0] src_addr_reg;
    logic [31:0] src_mask_reg;
    logic [31:0] dst_addr_reg;
    logic [31:0] dst_mask_reg;
    logic [31:0] l4_ports_reg;
    logic [15:0] service_reg;
    logic [NUM_PORTS-1:0] bind_ports_reg;
    logic bind_out_reg;
    logic [3:0] count_reg;
    logic [3:0] count_next;
    logic refused_reg;
    logic [31:0] prdata_reg;
    acl_pkg::rule_t rules_reg [MAX_RULES];
    acl_pkg::verdict_t verdict_reg;
    acl_pkg::verdict_t verdict_next;
    logic verdict_valid_reg;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire access = psel & penable;
    wire wr_en = access & pwrite;
    wire sel_ctrl = paddr == acl_pkg::OFF_CTRL;
    wire sel_sa = paddr == acl_pkg::OFF_SRC_ADDR;
    wire sel_sm = paddr == acl_pkg::OFF_SRC_MASK;
    wire sel_da = paddr == acl_pkg::OFF_DST_ADDR;
    wire sel_dm = paddr == acl_pkg::OFF_DST_MASK;
    wire sel_l4 = paddr == acl_pkg::OFF_L4_PORTS;
    wire sel_svc = paddr == acl_pkg::OFF_SERVICE;
    wire sel_cmd = paddr == acl_pkg::OFF_CMD;
    wire sel_bind = paddr == acl_pkg::OFF_BIND;
    wire sel_stat = paddr == acl_pkg::OFF_STATUS;
    wire sel_verd = paddr == acl_pkg::OFF_VERDICT;
    wire mapped = sel_ctrl | sel_sa | sel_sm | sel_da | sel_dm | sel_l4 | sel_svc
                  | sel_cmd | sel_bind | sel_stat | sel_verd;

    // Read data is captured in the setup cycle so prdata comes from a flop;
    // the access phase therefore always completes in one cycle.
    assign pready = access;
    assign pslverr = access & ~mapped;
    assign prdata = prdata_reg;

    wire [31:0] bind_word = {bind_out_reg, {(31 - NUM_PORTS){1'b0}}, bind_ports_reg};
    wire [31:0] status_word = {27'h0, refused_reg, count_reg};
    wire [31:0] rd_data =
        sel_ctrl ? 32'(ctrl_reg) :
        sel_sa ? src_addr_reg :
        sel_sm ? src_mask_reg :
        sel_da ? dst_addr_reg :
        sel_dm ? dst_mask_reg :
        sel_l4 ? l4_ports_reg :
        sel_svc ? {16'h0, service_reg} :
        sel_bind ? bind_word :
        sel_stat ? status_word :
        sel_verd ? 32'(verdict_reg) : acl_pkg::RESET_ZERO;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_reg <= acl_pkg::RESET_ZERO;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= rd_data;
        end
    end

    // ------------------------------------------------------------------
    // Staging registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= acl_pkg::rule_ctrl_t'(acl_pkg::RESET_ZERO);
            src_addr_reg <= acl_pkg::RESET_ZERO;
            src_mask_reg <= acl_pkg::MASK_ALL;
            dst_addr_reg <= acl_pkg::RESET_ZERO;
            dst_mask_reg <= acl_pkg::MASK_ALL;
            l4_ports_reg <= acl_pkg::RESET_ZERO;
            service_reg <= 16'h0000;
            bind_ports_reg <= '0;
            bind_out_reg <= 1'b0;
        end else if (wr_en) begin
            if (sel_ctrl) ctrl_reg <= acl_pkg::rule_ctrl_t'(pwdata);
            if (sel_sa) src_addr_reg <= pwdata;
            if (sel_sm) src_mask_reg <= pwdata;
            if (sel_da) dst_addr_reg <= pwdata;
            if (sel_dm) dst_mask_reg <= pwdata;
            if (sel_l4) l4_ports_reg <= pwdata;
            if (sel_svc) service_reg <= pwdata[15:0];
            if (sel_bind) bind_ports_reg <= pwdata[NUM_PORTS-1:0];
            if (sel_bind) bind_out_reg <= pwdata[31];
        end
    end

    // ------------------------------------------------------------------
    // Staged rule resolved into match form
    // ------------------------------------------------------------------
    acl_pkg::rule_t new_rule;
    wire [15:0] sport_num = l4_ports_reg[15:0];
    wire [15:0] dport_num = l4_ports_reg[31:16];
    wire [7:0] svc_cfg = service_reg[7:0];
    wire [7:0] svc_cfg_mask = service_reg[15:8];
    wire is_permit = ctrl_reg.permit;
    wire proto_kw = ctrl_reg.proto_mode == acl_pkg::CRIT_SYMBOL;
    wire proto_num = ctrl_reg.proto_mode == acl_pkg::CRIT_NUMBER;
    wire proto_on = proto_num | (proto_kw & (ctrl_reg.proto != acl_pkg::PROTO_KW_IP));
    wire [7:0] proto_val = proto_kw ? acl_pkg::proto_of(ctrl_reg.proto) : ctrl_reg.proto;
    wire proto_bad = proto_num & (ctrl_reg.proto == 8'h00);
    wire [15:0] sport_val = (ctrl_reg.sport_mode == acl_pkg::CRIT_SYMBOL)
                            ? acl_pkg::l4_port_of(sport_num[3:0]) : sport_num;
    wire [15:0] dport_val = (ctrl_reg.dport_mode == acl_pkg::CRIT_SYMBOL)
                            ? acl_pkg::l4_port_of(dport_num[3:0]) : dport_num;
    wire [7:0] dscp_val = 8'(svc_cfg << acl_pkg::DSCP_SHIFT);
    wire [7:0] prec_val = 8'(svc_cfg << acl_pkg::PREC_SHIFT);

    logic [7:0] svc_val;
    logic [7:0] svc_msk;
    always_comb begin
        unique case (ctrl_reg.svc_mode)
            acl_pkg::SVC_NONE: begin
                svc_val = 8'h00;
                svc_msk = 8'h00;
            end
            acl_pkg::SVC_DSCP: begin
                svc_val = dscp_val & acl_pkg::DSCP_MASK;
                svc_msk = acl_pkg::DSCP_MASK;
            end
            acl_pkg::SVC_PREC: begin
                svc_val = prec_val & acl_pkg::PREC_MASK;
                svc_msk = acl_pkg::PREC_MASK;
            end
            acl_pkg::SVC_MASKED: begin
                svc_val = svc_cfg;
                svc_msk = svc_cfg_mask;
            end
        endcase
    end

    always_comb begin
        new_rule = '0;
        new_rule.valid = 1'b1;
        new_rule.permit = is_permit;
        new_rule.match_all = ctrl_reg.match_all;
        new_rule.queue_en = is_permit & ctrl_reg.queue_en;
        new_rule.queue = ctrl_reg.egress_queue_select;
        new_rule.redir_en = is_permit & ctrl_reg.redir_en;
        new_rule.redir_port = ctrl_reg.redir_port;
        new_rule.proto_en = proto_on;
        new_rule.proto = proto_val;
        new_rule.src_addr = src_addr_reg;
        new_rule.src_mask = src_mask_reg;
        new_rule.dst_addr = dst_addr_reg;
        new_rule.dst_mask = dst_mask_reg;
        new_rule.sport_en = ctrl_reg.sport_mode != acl_pkg::CRIT_OFF;
        new_rule.sport_lo = sport_val;
        new_rule.sport_hi = sport_val;
        new_rule.dport_en = ctrl_reg.dport_mode != acl_pkg::CRIT_OFF;
        new_rule.dport_lo = dport_val;
        new_rule.dport_hi = dport_val;
        new_rule.svc_val = svc_val;
        new_rule.svc_mask = svc_msk;
    end

    // ------------------------------------------------------------------
    // Rule table commands
    // ------------------------------------------------------------------
    acl_pkg::cmd_t cmd_w;
    assign cmd_w = acl_pkg::cmd_t'(pwdata);
    wire cmd_wr = wr_en & sel_cmd & (cmd_w.op != acl_pkg::CMD_NONE);
    wire id_ok = (cmd_w.rule_id != 4'h0) && (32'(cmd_w.rule_id) <= MAX_RULES);
    wire [3:0] slot = id_ok ? cmd_w.rule_id - 4'h1 : 4'h0;
    wire slot_used = rules_reg[slot].valid;
    wire list_full = 32'(count_reg) >= MAX_RULES;
    wire add_ok = cmd_wr && cmd_w.op == acl_pkg::CMD_ADD && id_ok && !slot_used
                  && !list_full && !proto_bad;
    wire upd_ok = cmd_wr && cmd_w.op == acl_pkg::CMD_UPDATE && id_ok && slot_used && !proto_bad;
    wire del_ok = cmd_wr && cmd_w.op == acl_pkg::CMD_DELETE && id_ok && slot_used;
    wire cmd_refused = cmd_wr & ~(add_ok | upd_ok | del_ok);

    assign count_next = add_ok ? count_reg + 4'h1 : del_ok ? count_reg - 4'h1 : count_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= 4'h0;
            refused_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            if (cmd_wr) refused_reg <= cmd_refused;
        end
    end

    // ------------------------------------------------------------------
    // Per-rule storage and match
    // ------------------------------------------------------------------
    logic [MAX_RULES-1:0] hit_vec;

    for (genvar i = 0; i < MAX_RULES; i++) begin : g_rule
        wire this_slot = (32'(slot) == i);
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                rules_reg[i] <= '0;
            end else if ((add_ok || upd_ok) && this_slot) begin
                rules_reg[i] <= new_rule;
            end else if (del_ok && this_slot) begin
                rules_reg[i] <= '0;
            end
        end

        acl_pkg::rule_t r;
        assign r = rules_reg[i];
        wire m_proto = !r.proto_en || (pkt.proto == r.proto);
        wire m_src = ((pkt.src_addr ^ r.src_addr) & r.src_mask) == 32'h0;
        wire m_dst = ((pkt.dst_addr ^ r.dst_addr) & r.dst_mask) == 32'h0;
        wire m_sport = !r.sport_en || (pkt.sport >= r.sport_lo && pkt.sport <= r.sport_hi);
        wire m_dport = !r.dport_en || (pkt.dport >= r.dport_lo && pkt.dport <= r.dport_hi);
        wire m_svc = ((pkt.svc ^ r.svc_val) & r.svc_mask) == 8'h00;
        assign hit_vec[i] = r.valid
                            && (r.match_all || (m_proto && m_src && m_dst && m_sport
                                                && m_dport && m_svc));
    end

    // ------------------------------------------------------------------
    // Verdict
    // ------------------------------------------------------------------
    // lowest id wins
    logic [3:0] first_idx;
    always_comb begin
        first_idx = 4'h0;
        for (int k = MAX_RULES - 1; k >= 0; k--) begin
            if (hit_vec[k]) first_idx = 4'(k);
        end
    end

    wire port_bound = (32'(pkt.in_port) < NUM_PORTS) && bind_ports_reg[pkt.in_port];
    wire bound = port_bound && (pkt.outbound == bind_out_reg);
    wire any_hit = |hit_vec;
    acl_pkg::rule_t win;
    assign win = rules_reg[first_idx];

    always_comb begin
        verdict_next = '0;
        verdict_next.applied = bound;
        verdict_next.hit = bound & any_hit;
        verdict_next.permit = bound & any_hit & win.permit;
        verdict_next.rule_id = (bound & any_hit) ? first_idx + 4'h1 : 4'h0;
        verdict_next.queue_en = verdict_next.permit & win.queue_en;
        verdict_next.queue = verdict_next.queue_en ? win.queue : 3'h0;
        verdict_next.redir_en = verdict_next.permit & win.redir_en;
        verdict_next.redir_port = verdict_next.redir_en ? win.redir_port : '0;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            verdict_reg <= '0;
            verdict_valid_reg <= 1'b0;
        end else begin
            verdict_valid_reg <= pkt_valid;
            if (pkt_valid) verdict_reg <= verdict_next;
        end
    end

    assign verdict = verdict_reg;
    assign verdict_valid = verdict_valid_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_count_bound: assert property (32'(count_reg) <= MAX_RULES)
        else $error("rule count above maximum");
    a_full_add_refused: assert property (
        cmd_wr && cmd_w.op == acl_pkg::CMD_ADD && list_full |=> $stable(count_reg) && refused_reg)
        else $error("add accepted into a full list");
    a_add_counts: assert property (
        add_ok |=> count_reg == $past(count_reg) + 4'h1 && !refused_reg)
        else $error("accepted add did not grow the list");
    a_first_hit_wins: assert property (
        pkt_valid && bound && any_hit |=> verdict.hit
        && ($past(hit_vec) & ((1 << (verdict.rule_id - 4'h1)) - 1)) == '0)
        else $error("verdict rule is not the first hit");
    a_default_deny: assert property (
        pkt_valid && bound && !any_hit |=> verdict_valid && verdict.applied && !verdict.permit)
        else $error("missed packet not denied");
    a_unbound_skip: assert property (
        pkt_valid && !bound |=> !verdict.applied && !verdict.hit && verdict.rule_id == 4'h0)
        else $error("unbound packet was classified");
    a_deny_no_steer: assert property (
        verdict_valid && !verdict.permit |-> !verdict.redir_en && !verdict.queue_en)
        else $error("denied packet carries queue or redirect");
    a_match_all_hits: assert property (
        pkt_valid && bound && rules_reg[0].valid && rules_reg[0].match_all
        |=> verdict.hit && verdict.rule_id == 4'h1)
        else $error("match-all rule did not hit");
    a_sym_port_range: assert property (
        (add_ok || upd_ok) && ctrl_reg.sport_mode == acl_pkg::CRIT_SYMBOL
        |=> rules_reg[$past(slot)].sport_lo == acl_pkg::l4_port_of($past(sport_num[3:0]))
        && rules_reg[$past(slot)].sport_hi == rules_reg[$past(slot)].sport_lo)
        else $error("source port range not single-valued");

    c_permit_hit: cover property (verdict_valid && verdict.hit && verdict.permit);
    c_default_deny: cover property (verdict_valid && verdict.applied && !verdict.hit);
    c_full_refuse: cover property (cmd_wr && list_full ##1 refused_reg);
    c_redirect: cover property (verdict_valid && verdict.redir_en);

endmodule : ip_acl_packet_classifier

/* tb/ip_acl_packet_classifier_test.sv */
// Self-checking bench: rules loaded over APB, headers sent through the feed model.
// Assumes zero-wait APB and a verdict one cycle after each header.
module ip_acl_packet_classifier_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, pkt_valid, verdict_valid, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    acl_pkg::pkt_hdr_t pkt, h;
    acl_pkg::verdict_t verdict;
    int miscompares = 0;
    int samples_checked = 0;
    localparam acl_pkg::pkt_hdr_t HB = '{32'h0a010203, 32'hc0a80001, 8'h06, 8'hb8,
        16'h04d2, 16'h0050, 4'h0, 1'b0};
    localparam acl_pkg::verdict_t VHIT = '{1, 1, 1, 4'h2, 1, 3'h5, 1, 4'h3};
    localparam acl_pkg::verdict_t VALL = '{1, 1, 0, 4'h1, 0, 3'h0, 0, 4'h0};
    localparam acl_pkg::verdict_t VMISS = '{1, 0, 0, 4'h0, 0, 3'h0, 0, 4'h0};
    localparam acl_pkg::verdict_t VPL = '{1, 1, 1, 4'h2, 0, 3'h0, 0, 4'h0};
    ip_acl_packet_classifier ip_acl_packet_classifier_i (.clk(clk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pkt_valid(pkt_valid),
        .pkt(pkt), .verdict_valid(verdict_valid), .verdict(verdict));
    pipeline_feed pipeline_feed_i (.clk(clk), .pkt_valid(pkt_valid), .pkt(pkt));
    // ------------------------------------------------------------------
    // Bus, packet and compare helpers
    // ------------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cfg(input logic [3:0] id, input logic [31:0] c, input logic [31:0] sm);
        apb(1, acl_pkg::OFF_CTRL, c);
        apb(1, acl_pkg::OFF_SRC_ADDR, 32'h0a000000);
        apb(1, acl_pkg::OFF_SRC_MASK, sm);
        apb(1, acl_pkg::OFF_DST_MASK, 32'h0);
        apb(1, acl_pkg::OFF_L4_PORTS, 32'h00040000);
        apb(1, acl_pkg::OFF_SERVICE, 32'h0000002e);
        apb(1, acl_pkg::OFF_CMD, {24'h0, id, 4'h1});
    endtask : cfg
    task automatic pk(input acl_pkg::pkt_hdr_t x, input acl_pkg::verdict_t e);
        pipeline_feed_i.send(x);
        #1;
        chk("verdict_valid", 32'h1, {31'h0, verdict_valid});
        chk("verdict", {16'h0, e}, {16'h0, verdict});
    endtask : pk
    task automatic t_regs;
        apb(0, acl_pkg::OFF_STATUS, 32'h0);
        chk("status", 32'h0, rd);
        apb(0, 8'h2c, 32'h0);
        chk("pslverr", 32'h1, {31'h0, er});
        chk("unmapped", 32'h0, rd);
        apb(1, acl_pkg::OFF_BIND, 32'h1);
        pk(HB, VMISS);
        $display("test t_regs done");
    endtask : t_regs
    // Rule 2: permit, queue 5, redirect 3, TCP, DSCP 2e, HTTP destination.
    task automatic t_fields;
        cfg(4'h2, 32'h850601ed, 32'hff000000);
        pk(HB, VHIT);
        h = HB;
        h.svc = 8'hbb;
        pk(h, VHIT);
        h.svc = 8'hbc;
        pk(h, VMISS);
        h = HB;
        h.proto = 8'h11;
        pk(h, VMISS);
        h = HB;
        h.src_addr[24] = 1'b1;
        pk(h, VMISS);
        h = HB;
        h.src_addr[7:0] = 8'hff;
        pk(h, VHIT);
        h = HB;
        h.dport = 16'h0051;
        pk(h, VMISS);
        h = HB;
        h.in_port = 4'h1;
        pk(h, '0);
        h = HB;
        h.outbound = 1'b1;
        pk(h, '0);
        $display("test t_fields done");
    endtask : t_fields
    task automatic t_order;
        cfg(4'h1, 32'h2, 32'h0);
        pk(HB, VALL);
        apb(1, acl_pkg::OFF_CMD, 32'h13);
        pk(HB, VHIT);
        $display("test t_order done");
    endtask : t_order
    // Rule 2 updated in place: keyword protocol, numeric ports, precedence, then masked byte.
    task automatic t_modes;
        apb(1, acl_pkg::OFF_CTRL, 32'h5a030001);
        apb(1, acl_pkg::OFF_L4_PORTS, 32'h005004d2);
        apb(1, acl_pkg::OFF_SERVICE, 32'h5);
        apb(1, acl_pkg::OFF_CMD, 32'h22);
        pk(HB, VPL);
        h = HB;
        h.proto = 8'h11;
        pk(h, VMISS);
        h = HB;
        h.sport = 16'h04d3;
        pk(h, VMISS);
        h = HB;
        h.dport = 16'h0051;
        pk(h, VMISS);
        h = HB;
        h.svc = 8'hd8;
        pk(h, VMISS);
        apb(1, acl_pkg::OFF_CTRL, 32'h2e020001);
        apb(1, acl_pkg::OFF_L4_PORTS, 32'h2);
        apb(1, acl_pkg::OFF_SERVICE, 32'ha2a0);
        apb(1, acl_pkg::OFF_CMD, 32'h22);
        h = HB;
        h.proto = 8'h11;
        h.sport = 16'h0015;
        pk(h, VPL);
        h.svc = 8'hba;
        pk(h, VMISS);
        h.svc = 8'hb8;
        h.sport = 16'h0016;
        pk(h, VMISS);
        apb(1, acl_pkg::OFF_CTRL, 32'h01000001);
        apb(1, acl_pkg::OFF_CMD, 32'h22);
        apb(0, acl_pkg::OFF_STATUS, 32'h0);
        chk("status", 32'h11, rd);
        h.sport = 16'h0015;
        pk(h, VPL);
        $display("test t_modes done");
    endtask : t_modes
    task automatic t_full;
        for (int i = 1; i <= 9; i++) if (i != 2) cfg(4'(i), 32'h2, 32'h0);
        apb(0, acl_pkg::OFF_STATUS, 32'h0);
        chk("status", 32'h9, rd);
        cfg(4'ha, 32'h2, 32'h0);
        apb(0, acl_pkg::OFF_STATUS, 32'h0);
        chk("status", 32'h19, rd);
        pk(HB, VALL);
        $display("test t_full done");
    endtask : t_full
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_fields();
        t_order();
        t_modes();
        t_full();
        report_and_stop();
    end
endmodule : ip_acl_packet_classifier_test

/* tb/pipeline_feed.sv */
// Header source standing in for the switch forwarding pipeline.
// Assumes the classifier takes pkt at the rising edge where pkt_valid is high.
module pipeline_feed (
    input wire logic clk,
    output logic pkt_valid,
    output acl_pkg::pkt_hdr_t pkt
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        pkt_valid = 1'b0;
        pkt = '0;
    end
    // Between headers the bus shows the inverse, so a stale header cannot pass for a new one.
    task automatic send(input acl_pkg::pkt_hdr_t h);
        @(posedge clk);
        pkt_valid <= 1'b1;
        pkt <= h;
        @(posedge clk);
        pkt_valid <= 1'b0;
        pkt <= ~h;
    endtask : send
endmodule : pipeline_feed
